// File: design/ddsl_pkg.sv
// shared constants of the dual converter serial load link
// assumes both ends and the bench import it whole
//
// Contract
// - input buffers off after full word
// - completed word loads selected input register
// - load strobe high holds output registers
// - load strobe low makes output transparent
// - host writes both, then pulses strobe
// - output reloads only after input written
// - power mode from bits 13 and 12
// - mode codes select termination or normal
// - power-down swaps amplifier for 1k or 100k termination, or leaves output open in hi-Z mode
// - power-down keeps register contents
// - wake-up latency before output valid
// - data sampled on falling serial clock
// - frame select held across whole word
// - host sends most significant bit first
// - host makes clock, low frame, 16 bits
// - bit 15 channel, bit 14 reference buffer
// - sixteen falling edges, then ignore clocks
// - early frame end abandons the word
// - reset clears registers, normal, unbuffered
package ddsl_pkg;
  localparam int WORD_BITS = 16;
  localparam int CODE_W = 12;
  localparam logic [3:0] LAST_BIT = 4'hF;
  localparam int CH_BIT = 15;
  localparam int BUF_BIT = 14;
  localparam int PM_HI_BIT = 13;
  localparam int PM_LO_BIT = 12;
  localparam int CODE_MSB = 11;
  localparam logic [CODE_W-1:0] CODE_RST = 12'h000;
  // power mode field
  typedef enum logic [1:0] {
    PM_NORMAL = 2'b00,
    PM_PD_1K = 2'b01,
    PM_PD_100K = 2'b10,
    PM_PD_HIZ = 2'b11
  } ddsl_pmode_t;
  // timing
  localparam int SYS_PERIOD_NS = 20;
  localparam int WAKE_TIME_NS = 2500;
  localparam logic [7:0] WAKE_CYC = 8'((WAKE_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);
  localparam logic [3:0] SCLK_HALF_CYC = 4'h4;
  localparam logic [3:0] LOAD_PULSE_CYC = 4'h8;
  // host register map over the bus
  localparam logic [3:0] WORD_OFF = 4'h0;
  localparam logic [3:0] LOAD_OFF = 4'h4;
  localparam logic [3:0] STAT_OFF = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : ddsl_pkg

// File: design/ddsl_if.sv
// three-wire link plus load strobe between host and converter
// assumes host drives every wire; device only listens
`timescale 1ns/10ps
`default_nettype none
interface ddsl_if;
  logic sclk;
  logic din;
  logic sync_n;
  logic output_load_strobe_n;
  modport host (output sclk, output din, output sync_n, output output_load_strobe_n);
  modport device (input sclk, input din, input sync_n, input output_load_strobe_n);
endinterface : ddsl_if
`default_nettype wire

// File: design/ddsl_device.sv
// converter digital control: serial receive, double buffers, power modes
// assumes link wires are asynchronous to SYS_CLK_IN and are synchronised here
`timescale 1ns/10ps
`default_nettype none
module ddsl_device
  import ddsl_pkg::*;
(
  input wire logic SYS_CLK_IN,
  input wire logic RST_IN,
  ddsl_if.device LINK,
  output logic [CODE_W-1:0] CODE_A_OUT,
  output logic [CODE_W-1:0] CODE_B_OUT,
  output logic [1:0] REF_BUF_OUT,
  output logic [1:0] AMP_CONNECT_OUT,
  output logic [1:0] TERM_1K_OUT,
  output logic [1:0] TERM_100K_OUT,
  output logic [1:0] OUT_VALID_OUT,
  output logic LINK_BUF_ON_OUT
);
  function automatic logic is_pd(input logic [1:0] m);
    is_pd = (m != PM_NORMAL);
  endfunction : is_pd

  logic [3:0] meta_q;
  logic [3:0] sync_q;
  logic sclk_prev_q;
  logic frame_prev_q;
  logic active_q;
  logic [3:0] cnt_q;
  logic [WORD_BITS-2:0] sr_q;
  logic [1:0][CODE_W-1:0] in_q;
  logic [1:0][CODE_W-1:0] dac_q;
  logic [1:0][1:0] mode_q;
  logic [1:0] buf_q;
  logic [1:0] pend_q;
  logic [1:0][7:0] wake_q;
  logic [1:0] amp_q;
  logic [1:0] t1k_q;
  logic [1:0] t100k_q;
  logic [1:0] valid_q;

  // synchroniser: first stage read only by second
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      meta_q <= 4'hE; // serial clock stage at its idle low level
      sync_q <= 4'hE;
    end
    else
    begin
      meta_q <= {LINK.output_load_strobe_n, LINK.sync_n, LINK.din, LINK.sclk};
      sync_q <= meta_q;
    end
  end

  wire sclk_s = sync_q[0];
  wire din_s = sync_q[1];
  wire frame_n_s = sync_q[2];
  wire load_low = ~sync_q[3];
  wire sclk_fall = sclk_prev_q & ~sclk_s; // sample edge
  wire frame_fall = frame_prev_q & ~frame_n_s;
  wire shift_en = active_q & ~frame_n_s & sclk_fall;
  wire word_done = shift_en & (cnt_q == LAST_BIT);
  wire [WORD_BITS-1:0] word = {sr_q, din_s};
  wire ch = word[CH_BIT];
  wire [1:0] wr_ch = word_done ? (ch ? 2'b10 : 2'b01) : 2'b00;
  wire [1:0] new_mode = {word[PM_HI_BIT], word[PM_LO_BIT]};

  // edge history for the sampled link lines
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      sclk_prev_q <= 1'b0;
      frame_prev_q <= 1'b1;
    end
    else
    begin
      sclk_prev_q <= sclk_s;
      frame_prev_q <= frame_n_s;
    end
  end

  // frame receive: sixteen falling edges then buffers off
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      active_q <= 1'b0;
      cnt_q <= 4'h0;
      sr_q <= 15'h0000;
    end
    else if (frame_fall)
    begin
      active_q <= 1'b1; // buffers back on at frame start
      cnt_q <= 4'h0;
    end
    else if (frame_n_s)
    begin
      active_q <= 1'b0; // early rise abandons word
      cnt_q <= 4'h0;
    end
    else if (shift_en)
    begin
      sr_q <= word[WORD_BITS-2:0];
      cnt_q <= cnt_q + 4'h1;
      if (word_done)
      begin
        active_q <= 1'b0; // further clocks ignored
      end
    end
  end

  // per channel input, output, pending and mode state
  for (genvar i = 0; i < 2; i++)
  begin : g_ch
    wire load_now = load_low & pend_q[i]; // strobe independent of serial
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
    begin
      if (RST_IN)
      begin
        in_q[i] <= CODE_RST;
        dac_q[i] <= CODE_RST;
        mode_q[i] <= PM_NORMAL;
        buf_q[i] <= 1'b0;
        pend_q[i] <= 1'b0;
      end
      else
      begin
        if (wr_ch[i])
        begin
          in_q[i] <= word[CODE_MSB:0];
          mode_q[i] <= new_mode; // addressed channel only
          buf_q[i] <= word[BUF_BIT];
        end
        if (load_now)
        begin
          dac_q[i] <= in_q[i]; // transparent while low held while high
        end
        pend_q[i] <= wr_ch[i] | (pend_q[i] & ~load_now); // set beats clear
      end
    end

    // output stage and wake-up timing; codes untouched by power-down
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
    begin
      if (RST_IN)
      begin
        wake_q[i] <= 8'h00;
        amp_q[i] <= 1'b1;
        t1k_q[i] <= 1'b0;
        t100k_q[i] <= 1'b0;
        valid_q[i] <= 1'b1;
      end
      else
      begin
        amp_q[i] <= ~is_pd(mode_q[i]);
        t1k_q[i] <= (mode_q[i] == PM_PD_1K);
        t100k_q[i] <= (mode_q[i] == PM_PD_100K);
        if (is_pd(mode_q[i]))
        begin
          wake_q[i] <= WAKE_CYC;
        end
        else if (wake_q[i] != 8'h00)
        begin
          wake_q[i] <= wake_q[i] - 8'h01;
        end
        valid_q[i] <= ~is_pd(mode_q[i]) & (wake_q[i] == 8'h00);
      end
    end
  end

  assign CODE_A_OUT = dac_q[0];
  assign CODE_B_OUT = dac_q[1];
  assign REF_BUF_OUT = buf_q;
  assign AMP_CONNECT_OUT = amp_q;
  assign TERM_1K_OUT = t1k_q;
  assign TERM_100K_OUT = t100k_q;
  assign OUT_VALID_OUT = valid_q;
  assign LINK_BUF_ON_OUT = active_q;
endmodule : ddsl_device
`default_nettype wire

// File: design/ddsl_host.sv
// host end: AXI4-Lite registers driving the serial link and load strobe
// assumes bus master on SYS_CLK_IN; device samples the link asynchronously
`timescale 1ns/10ps
`default_nettype none
module ddsl_host
  import ddsl_pkg::*;
(
  input wire logic SYS_CLK_IN,
  input wire logic RST_IN,
  ddsl_if.host LINK,
  input wire logic [3:0] AWADDR_IN,
  input wire logic AWVALID_IN,
  output logic AWREADY_OUT,
  input wire logic [31:0] WDATA_IN,
  input wire logic [3:0] WSTRB_IN,
  input wire logic WVALID_IN,
  output logic WREADY_OUT,
  output logic [1:0] BRESP_OUT,
  output logic BVALID_OUT,
  input wire logic BREADY_IN,
  input wire logic [3:0] ARADDR_IN,
  input wire logic ARVALID_IN,
  output logic ARREADY_OUT,
  output logic [31:0] RDATA_OUT,
  output logic [1:0] RRESP_OUT,
  output logic RVALID_OUT,
  input wire logic RREADY_IN
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LEAD = 3'b001,
    ST_HIGH = 3'b010,
    ST_LOW = 3'b011,
    ST_TAIL = 3'b100,
    ST_GAP = 3'b101
  } ddsl_hstate_t;

  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic aw_held_q, w_held_q;
  logic [3:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [WORD_BITS-1:0] word_q, tx_q;
  ddsl_hstate_t st_q;
  logic [3:0] div_q, bit_q, load_cnt_q;
  logic sclk_q, din_q, sync_n_q, load_n_q;

  // write/read decode
  wire wr_fire = aw_held_q & w_held_q & ~bvalid_q;
  wire wr_known = (awaddr_q == WORD_OFF) | (awaddr_q == LOAD_OFF) | (awaddr_q == STAT_OFF);
  wire busy = (st_q != ST_IDLE);
  wire go = wr_fire & (awaddr_q == WORD_OFF) & wstrb_q[0] & wstrb_q[1] & ~busy;
  wire load_go = wr_fire & (awaddr_q == LOAD_OFF) & wstrb_q[0] & wdata_q[0] & load_n_q;
  wire [31:0] status = {30'h0, ~load_n_q, busy};
  wire rd_known = (ARADDR_IN == WORD_OFF) | (ARADDR_IN == LOAD_OFF) | (ARADDR_IN == STAT_OFF);
  wire [31:0] rd_mux = (ARADDR_IN == WORD_OFF) ? {16'h0, word_q} :
                       (ARADDR_IN == STAT_OFF) ? status : 32'h0;
  wire tick = (div_q == SCLK_HALF_CYC - 4'h1);

  // write channels taken in either order, response after both
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end
    else
    begin
      if (AWVALID_IN & awready_q)
      begin
        aw_held_q <= 1'b1;
        awaddr_q <= AWADDR_IN;
        awready_q <= 1'b0;
      end
      if (WVALID_IN & wready_q)
      begin
        w_held_q <= 1'b1;
        wdata_q <= WDATA_IN;
        wstrb_q <= WSTRB_IN;
        wready_q <= 1'b0;
      end
      if (wr_fire)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_known ? RESP_OKAY : RESP_SLVERR;
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
      end
      if (bvalid_q & BREADY_IN)
      begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // read channel: answer one cycle after address taken
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= RESP_OKAY;
    end
    else if (ARVALID_IN & arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_q & RREADY_IN)
    begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // serial engine: own clock, low frame, one 16-bit word per frame
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      st_q <= ST_IDLE;
      div_q <= 4'h0;
      bit_q <= 4'h0;
      word_q <= 16'h0000;
      tx_q <= 16'h0000;
      sclk_q <= 1'b0;
      din_q <= 1'b0;
      sync_n_q <= 1'b1;
    end
    else
    begin
      div_q <= (st_q == ST_IDLE || tick) ? 4'h0 : div_q + 4'h1;
      unique case (st_q)
        ST_IDLE:
        begin
          if (go)
          begin
            word_q <= wdata_q[WORD_BITS-1:0];
            tx_q <= wdata_q[WORD_BITS-1:0];
            sync_n_q <= 1'b0;
            bit_q <= 4'h0;
            st_q <= ST_LEAD;
          end
        end
        ST_LEAD, ST_LOW:
        begin
          if (tick)
          begin
            sclk_q <= 1'b1; // data changes on rise, clock idles low
            din_q <= tx_q[WORD_BITS-1]; // msb first
            tx_q <= {tx_q[WORD_BITS-2:0], 1'b0};
            st_q <= ST_HIGH;
          end
        end
        ST_HIGH:
        begin
          if (tick)
          begin
            sclk_q <= 1'b0; // device samples here
            bit_q <= bit_q + 4'h1;
            st_q <= (bit_q == LAST_BIT) ? ST_TAIL : ST_LOW; // frame low over all bits
          end
        end
        ST_TAIL:
        begin
          if (tick)
          begin
            sync_n_q <= 1'b1;
            st_q <= ST_GAP;
          end
        end
        ST_GAP:
        begin
          if (tick)
          begin
            st_q <= ST_IDLE;
          end
        end
        default:
        begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // load strobe pulse after software has written both channels
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      load_n_q <= 1'b1;
      load_cnt_q <= 4'h0;
    end
    else if (load_go)
    begin
      load_n_q <= 1'b0;
      load_cnt_q <= LOAD_PULSE_CYC - 4'h1;
    end
    else if (!load_n_q)
    begin
      if (load_cnt_q == 4'h0)
      begin
        load_n_q <= 1'b1;
      end
      else
      begin
        load_cnt_q <= load_cnt_q - 4'h1;
      end
    end
  end

  assign AWREADY_OUT = awready_q;
  assign WREADY_OUT = wready_q;
  assign BVALID_OUT = bvalid_q;
  assign BRESP_OUT = bresp_q;
  assign ARREADY_OUT = arready_q;
  assign RVALID_OUT = rvalid_q;
  assign RDATA_OUT = rdata_q;
  assign RRESP_OUT = rresp_q;
  assign LINK.sclk = sclk_q;
  assign LINK.din = din_q;
  assign LINK.sync_n = sync_n_q;
  assign LINK.output_load_strobe_n = load_n_q;
endmodule : ddsl_host
`default_nettype wire

// File: test/ddsl_checker.sv
// wire timing checks on the host-to-converter link
// assumes it sits beside the interface that joins the two ends
`timescale 1ns/10ps
`default_nettype none
module ddsl_checker
  import ddsl_pkg::*;
(
  input wire logic SYS_CLK_IN,
  input wire logic RST_IN,
  input wire logic sclk,
  input wire logic din,
  input wire logic sync_n,
  input wire logic output_load_strobe_n
);
  logic [4:0] falls_q;
  // counts clock falls inside the open frame
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN) falls_q <= 5'h00;
    else if (sync_n) falls_q <= 5'h00;
    else if ($fell(sclk)) falls_q <= falls_q + 5'h01;
  end
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (RST_IN);
  sequence high_half;
    sclk [*4] ##1 !sclk;
  endsequence
  sequence low_pulse;
    !output_load_strobe_n [*8] ##1 output_load_strobe_n;
  endsequence
  idle_clk_low_a: assert property (sync_n |-> !sclk)
    else $error("serial clock high outside frame");
  clk_half_a: assert property ($rose(sclk) |-> high_half)
    else $error("serial clock half period wrong");
  din_steady_a: assert property (!sync_n && $past(sclk) |-> $stable(din))
    else $error("data moved while clock high");
  frame_lead_a: assert property ($fell(sync_n) |-> !sclk [*4])
    else $error("clock edge too soon after frame start");
  frame_hold_a: assert property ($fell(sclk) |-> !sync_n)
    else $error("clock fall outside frame");
  word_count_a: assert property ($rose(sync_n) |-> falls_q == 5'h10)
    else $error("frame did not carry sixteen falls");
  frame_gap_a: assert property ($rose(sync_n) |-> sync_n [*3])
    else $error("frame gap too short");
  strobe_pulse_a: assert property ($fell(output_load_strobe_n) |-> low_pulse)
    else $error("load strobe pulse length wrong");
endmodule : ddsl_checker
`default_nettype wire

// File: test/dual_dac_serial_load_control_tb.sv
// bench: host and converter joined, plus a converter driven directly
// assumes the design package, interface and both ends compiled first
`timescale 1ns/10ps
`default_nettype none
module dual_dac_serial_load_control_tb
  import ddsl_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, lbuf2;
  logic [1:0] bresp, rresp, ref_buf, amp, t1k, t100k, ovld, r, bf;
  logic [31:0] rdata, d;
  logic [11:0] code_a, code_b, code2_a, ca, cb, out_a, out_b;
  logic sclk_q = 1'b0;
  logic [15:0] cap = 16'h0000;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  ddsl_if lk ();
  ddsl_if lk2 ();
  ddsl_host u_ddsl_host (.SYS_CLK_IN(sys_clk), .RST_IN(rst), .LINK(lk),
    .AWADDR_IN(awaddr), .AWVALID_IN(awvalid), .AWREADY_OUT(awready), .WDATA_IN(wdata),
    .WSTRB_IN(wstrb), .WVALID_IN(wvalid), .WREADY_OUT(wready), .BRESP_OUT(bresp),
    .BVALID_OUT(bvalid), .BREADY_IN(bready), .ARADDR_IN(araddr), .ARVALID_IN(arvalid),
    .ARREADY_OUT(arready), .RDATA_OUT(rdata), .RRESP_OUT(rresp), .RVALID_OUT(rvalid),
    .RREADY_IN(rready));
  ddsl_device u_ddsl_device (.SYS_CLK_IN(sys_clk), .RST_IN(rst), .LINK(lk),
    .CODE_A_OUT(code_a), .CODE_B_OUT(code_b), .REF_BUF_OUT(ref_buf),
    .AMP_CONNECT_OUT(amp), .TERM_1K_OUT(t1k), .TERM_100K_OUT(t100k),
    .OUT_VALID_OUT(ovld), .LINK_BUF_ON_OUT());
  ddsl_device u_ddsl_device_2 (.SYS_CLK_IN(sys_clk), .RST_IN(rst), .LINK(lk2),
    .CODE_A_OUT(code2_a), .CODE_B_OUT(), .REF_BUF_OUT(), .AMP_CONNECT_OUT(),
    .TERM_1K_OUT(), .TERM_100K_OUT(), .OUT_VALID_OUT(), .LINK_BUF_ON_OUT(lbuf2));
  ddsl_checker u_ddsl_checker (.SYS_CLK_IN(sys_clk), .RST_IN(rst), .sclk(lk.sclk),
    .din(lk.din), .sync_n(lk.sync_n), .output_load_strobe_n(lk.output_load_strobe_n));
  always #10 sys_clk = ~sys_clk;
  // captures link bits at each clock fall, timeout watch
  always @(posedge sys_clk)
  begin
    sclk_q <= lk.sclk;
    if (sclk_q && !lk.sclk && !lk.sync_n) cap <= {cap[14:0], lk.din};
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_errors++;
      test_done();
    end
  end
  // expected amplifier lines: channel a normal, channel b in mode m
  function automatic logic [1:0] exp_amp(input int m);
    exp_amp = {m == 0, 1'b1};
  endfunction : exp_amp
  // expected termination lines {1k, 100k} for channel b in mode m
  function automatic logic [3:0] exp_term(input int m);
    exp_term = {m == 1, 1'b0, m == 2, 1'b0};
  endfunction : exp_term
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task axw(input logic [3:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask : axw
  task axr(input logic [3:0] a);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : axr
  // polls status until link and strobe are quiet
  task wait_idle();
    d = 32'h3;
    while (d[1:0] != 2'b00) axr(STAT_OFF);
    repeat (6) @(posedge sys_clk);
  endtask : wait_idle
  task send(input logic [15:0] w);
    axw(WORD_OFF, {16'h0000, w});
    chk("wr resp", r, RESP_OKAY);
    wait_idle();
    chk("wire word", cap, w);
  endtask : send
  // direct driver for the second converter
  task drv2(input logic [15:0] w, input int n);
    @(posedge sys_clk);
    lk2.sync_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk("buf on", lbuf2, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      lk2.sclk <= 1'b1;
      lk2.din <= w[15 - (i % 16)];
      repeat (4) @(posedge sys_clk);
      lk2.sclk <= 1'b0;
      repeat (4) @(posedge sys_clk);
    end
    repeat (4) @(posedge sys_clk);
    if (n >= 16) chk("buf off", lbuf2, 1'b0);
    lk2.sync_n <= 1'b1;
    lk2.din <= ~lk2.din;
    repeat (6) @(posedge sys_clk);
  endtask : drv2
  task test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  initial
  begin
    lk2.sclk = 1'b0;
    lk2.din = 1'b0;
    lk2.sync_n = 1'b1;
    lk2.output_load_strobe_n = 1'b0;
    out_a = 12'h000;
    out_b = 12'h000;
    void'($urandom(32'hA937417E));
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk("rst codes", {code_a, code_b}, 24'h000000);
    chk("rst mode", {ref_buf, amp, t1k, t100k}, 8'h30);
    // double-buffered writes, then one strobe for both
    for (int i = 0; i < 4; i++)
    begin
      ca = (i == 0) ? 12'hFFF : 12'($urandom);
      cb = (i == 0) ? 12'h000 : 12'($urandom);
      bf = 2'($urandom);
      send({1'b0, bf[0], 2'b00, ca});
      send({1'b1, bf[1], 2'b00, cb});
      chk("ref buf", ref_buf, bf);
      chk("code held", {code_a, code_b}, {out_a, out_b});
      axw(LOAD_OFF, 32'h1);
      wait_idle();
      chk("code load", {code_a, code_b}, {ca, cb});
      out_a = ca;
      out_b = cb;
    end
    // each power-down mode on channel b only
    for (int m = 1; m < 4; m++)
    begin
      send({1'b1, 1'b0, 2'(m), out_b});
      chk("amp", amp, exp_amp(m));
      chk("term", {t1k, t100k}, exp_term(m));
      chk("valid off", ovld, 2'b01);
      chk("code kept", code_b, out_b);
    end
    send({4'b1000, out_b});
    chk("amp back", amp, exp_amp(0));
    chk("wake early", ovld, 2'b01);
    repeat (125) @(posedge sys_clk);
    chk("wake done", ovld, 2'b11);
    axr(WORD_OFF);
    chk("word rd", d[15:0], {4'b1000, out_b});
    chk("rd resp", r, RESP_OKAY);
    axr(4'hC);
    chk("unmapped", r, RESP_SLVERR);
    axw(4'hC, 32'h0000_0001);
    chk("wr unmapped", r, RESP_SLVERR);
    // word written while the link is busy is dropped
    axw(WORD_OFF, {16'h0000, 4'b1000, out_b});
    axw(WORD_OFF, 32'h0000_5FFF);
    chk("busy resp", r, RESP_OKAY);
    wait_idle();
    chk("busy drop", cap, {4'b1000, out_b});
    // word write with partial strobes is ignored
    wstrb <= 4'h1;
    axw(WORD_OFF, 32'h0000_5FFF);
    wstrb <= 4'hF;
    chk("strb resp", r, RESP_OKAY);
    axr(STAT_OFF);
    chk("strb idle", d, 32'h0);
    axr(WORD_OFF);
    chk("strb drop", d[15:0], {4'b1000, out_b});
    // second converter: strobe held low, full, short and long frames
    drv2(16'h0123, 16);
    chk("full", code2_a, 12'h123);
    drv2(16'h0ABC, 15);
    chk("abort", code2_a, 12'h123);
    drv2(16'h0456, 17);
    chk("extra clk", code2_a, 12'h456);
    test_done();
  end
endmodule : dual_dac_serial_load_control_tb
`default_nettype wire
